// [logic/uart_pkg.sv]
// Purpose: Shared constants and types for the serial receiver and its far-end transmitter.
// Assumes: One kernel clock; 8-bit characters; 16-bit baud divisor.
// Notes: Stop and clock-source codes are the values driven on the configuration ports.
package uart_pkg;

  localparam int DIV_W = 16;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int TICK_W = 5;

  // -----------------------------------------------------------------
  // Sampling and baud timing
  // -----------------------------------------------------------------
  localparam logic [TICK_W-1:0] OS16_TICKS = 5'h10;
  localparam logic [TICK_W-1:0] OS8_TICKS = 5'h08;
  localparam logic [TICK_W-1:0] SAMPLE_SPAN = 5'h02;
  localparam logic [DIV_W:0] ACC_STEP = 17'h00010;
  localparam logic [DIV_W-1:0] MIN_DIV = 16'h0010;
  localparam logic [DIV_W-1:0] BAUD_RESET = 16'h0010;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // -----------------------------------------------------------------
  // Configuration codes
  // -----------------------------------------------------------------
  localparam logic [1:0] STOP_ONE = 2'h0;
  localparam logic [1:0] STOP_HALF = 2'h1;
  localparam logic [1:0] STOP_TWO = 2'h2;
  localparam logic [1:0] STOP_ONEHALF = 2'h3;

  localparam logic [1:0] SRC_BUS = 2'h0;
  localparam logic [1:0] SRC_CORE = 2'h1;
  localparam logic [1:0] SRC_FAST_INT = 2'h2;
  localparam logic [1:0] SRC_LOW_EXT = 2'h3;
  localparam logic DUAL_DOMAIN = 1'b1;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_type;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_type;

endpackage

// [logic/serial_link_if.sv]
// Purpose: Serial receive line between the far-end transmitter and the receiver.
// Assumes: The line idles high; only the far end drives it.
// Notes: The receiver treats the line as asynchronous and synchronises it itself.
interface serial_link_if;
  logic line;
  modport device (input line);
  modport far (output line);
endinterface

// [logic/uart_rx_end.sv]
// Purpose: Receive-side bit sampling, error flags and shared baud generator.
// Assumes: Software keeps the baud divisor at 16 or more and the clock source fixed while on.
// Notes: Received characters pass a 16-word FIFO and a registered output stage.
//
// Overview of operation
// - Pick clock source before enabling unit.
// - Source selectable only with dual domain support.
// - Oversample select picks 16x or 8x sampling.
// - Three-sample majority; disagreement raises noise.
// - Single-sample mode never raises noise flag.
// - Mixed triples give majority value plus noise.
// - Noise flag rises with buffer-full; data kept.
// - Errors interrupt only in multibuffer with enable.
// - Noise flag holds until noise-clear write.
// - Special modes force 16x oversampling.
// - Bad stop bit flags framing, stores character.
// - Framing-clear write resets framing error flag.
// - Stop length one/two, half/one-and-half.
// - Half stop bit is never sampled.
// - Single stop sampled on ticks 8-10.
// - One-and-half stop sampled ticks 16-18.
// - Card NACK low shows as framing error.
// - Two stops: first checked, full after it.
// - Shared baud from kernel clock and divisor.
// - At 8x, register packs divisor shifted right.
// - New divisor takes effect right after write.
// - Software keeps divisor at sixteen or more.

// ---------------------------------------------------------------------
// Receive FIFO
// ---------------------------------------------------------------------
module rx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk, // Kernel clock.
  input wire logic nrst, // Synchronous reset, active low.
  input wire logic in_valid, // Write request.
  output logic in_ready, // Space available.
  input wire logic [WIDTH-1:0] in_data, // Write data.
  output logic out_valid, // Data available.
  input wire logic out_ready, // Read acknowledge.
  output logic [WIDTH-1:0] out_data // Head word.
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wptr_reg;
  logic [AW:0] rptr_reg;
  wire do_write = in_valid & in_ready;
  wire do_read = out_valid & out_ready;
  wire ptr_same = wptr_reg[AW-1:0] == rptr_reg[AW-1:0];

  assign in_ready = ~(ptr_same & (wptr_reg[AW] != rptr_reg[AW]));
  assign out_valid = wptr_reg != rptr_reg;
  assign out_data = mem[rptr_reg[AW-1:0]];

  always_ff @(posedge clk) begin
    if (do_write) begin
      mem[wptr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else begin
      wptr_reg <= wptr_reg + (AW+1)'(do_write);
      rptr_reg <= rptr_reg + (AW+1)'(do_read);
    end
  end
endmodule // rx_fifo

// ---------------------------------------------------------------------
// Receiver end
// ---------------------------------------------------------------------
module uart_rx_end (
  input wire logic clk, // Kernel clock, 10 MHz.
  input wire logic nrst, // Synchronous reset, active low.
  serial_link_if.device link, // Serial receive line.
  input wire logic unit_on_bit, // Unit enable.
  input wire logic rx_side_on, // Receiver enable.
  input wire logic [1:0] clk_src_sel, // Requested kernel clock source.
  input wire logic oversample_half_select, // 1 selects 8x oversampling unless special_mode is set.
  input wire logic single_sample_select, // 1 selects one sample per bit.
  input wire logic special_mode, // LIN, smartcard or infrared mode.
  input wire logic [1:0] stop_sel, // Expected stop length code.
  input wire logic multibuffer, // DMA operation.
  input wire logic error_irq_on, // Error interrupt enable.
  input wire logic baud_wr, // Write strobe for the baud register.
  input wire logic [uart_pkg::DIV_W-1:0] baud_wdata, // Baud register write data.
  input wire logic flag_clear_wr, // Write strobe for the flag clear register.
  input wire logic noise_clear_bit, // Clears the noise flag.
  input wire logic framing_clear_bit, // Clears the framing error flag.
  input wire logic rx_ready, // Consumer takes the character.
  output logic [uart_pkg::DATA_W-1:0] rx_data_reg, // Received character.
  output logic rx_valid, // Character available.
  output logic rx_buffer_full, // Any received data held.
  output logic noise_flag, // Noise seen in a stored frame.
  output logic framing_error_flag, // Stop bit missing in a stored frame.
  output logic error_irq, // Error interrupt request.
  output logic [uart_pkg::DIV_W-1:0] baud_rate_reg, // Baud register readback.
  output logic [1:0] kernel_src // Active kernel clock source.
);
  import uart_pkg::*;

  rx_state_type state_reg, state_next;
  logic line_meta_reg, line_sync_reg, line_prev_reg;
  logic [DIV_W-1:0] acc_reg;
  logic [TICK_W-1:0] cnt_reg;
  logic [1:0] samp_reg;
  logic [2:0] bit_idx_reg;
  logic [DATA_W-1:0] shift_reg;
  logic noise_acc_reg, stop_bad_reg;
  logic [DATA_W-1:0] fifo_data;
  logic fifo_valid, fifo_in_ready;

  // -------------------------------------------------------------------
  // Baud generator
  // -------------------------------------------------------------------
  // Both oversampling modes reduce to one tick every div/16 clocks, so a
  // phase accumulator serves both and keeps the fractional divisor exact.
  wire os8_eff = oversample_half_select & ~special_mode;
  wire [DIV_W-1:0] div_eff = os8_eff ?
    {baud_rate_reg[DIV_W-1:4], baud_rate_reg[2:0], 1'b0} : baud_rate_reg;
  wire [DIV_W:0] acc_sum = {1'b0, acc_reg} + ACC_STEP;
  wire tick = unit_on_bit & (acc_sum >= {1'b0, div_eff});
  wire [DIV_W-1:0] acc_next = (baud_wr | ~unit_on_bit) ? '0 :
    tick ? DIV_W'(acc_sum - {1'b0, div_eff}) : acc_sum[DIV_W-1:0];

  // -------------------------------------------------------------------
  // Sample positions
  // -------------------------------------------------------------------
  wire [TICK_W-1:0] n_ticks = os8_eff ? OS8_TICKS : OS16_TICKS;
  wire [TICK_W-1:0] half_ticks = n_ticks >> 1;
  wire in_stop = state_reg == RX_STOP;
  wire stop_onehalf = stop_sel == STOP_ONEHALF;
  wire stop_half = stop_sel == STOP_HALF;
  wire [TICK_W-1:0] base = (in_stop & stop_onehalf) ? n_ticks : half_ticks;
  wire [TICK_W-1:0] stop_end = stop_half ? half_ticks :
    stop_onehalf ? TICK_W'(n_ticks + half_ticks) : n_ticks;
  wire [TICK_W-1:0] end_ticks = in_stop ? stop_end : n_ticks;
  wire busy = state_reg != RX_IDLE;
  wire [TICK_W-1:0] cnt_inc = cnt_reg + TICK_W'(1);
  wire in_window = (cnt_inc >= base) & (cnt_inc < TICK_W'(base + SAMPLE_SPAN));
  wire take = tick & busy & in_window & ~(in_stop & stop_half);
  wire eval = tick & busy & (cnt_inc == TICK_W'(base + SAMPLE_SPAN)) &
    ~(in_stop & stop_half);
  wire bit_end = tick & busy & (cnt_inc == end_ticks);

  // -------------------------------------------------------------------
  // Bit value and noise
  // -------------------------------------------------------------------
  wire s0 = samp_reg[1];
  wire s1 = samp_reg[0];
  wire s2 = line_sync_reg;
  wire majority = (s0 & s1) | (s0 & s2) | (s1 & s2);
  wire disagree = ~((s0 & s1 & s2) | ~(s0 | s1 | s2));
  wire bit_val = single_sample_select ? s1 : majority;
  wire noise_hit = eval & disagree & ~single_sample_select;
  wire falling = line_prev_reg & ~line_sync_reg;
  wire go = unit_on_bit & rx_side_on & falling & fifo_in_ready;
  wire push = in_stop & bit_end;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      RX_IDLE: if (go) state_next = RX_START;
      RX_START: begin
        if (eval & bit_val) begin
          state_next = RX_IDLE;
        end else if (bit_end) begin
          state_next = RX_DATA;
        end
      end
      RX_DATA: if (bit_end && bit_idx_reg == LAST_BIT) state_next = RX_STOP;
      RX_STOP: if (bit_end) state_next = RX_IDLE;
    endcase
    if (!unit_on_bit || !rx_side_on) begin
      state_next = RX_IDLE;
    end
  end

  // -------------------------------------------------------------------
  // Output stage and flags
  // -------------------------------------------------------------------
  wire load = fifo_valid & (~rx_valid | rx_ready);
  wire valid_next = load | (rx_valid & ~rx_ready);
  wire noise_clr = flag_clear_wr & noise_clear_bit;
  wire fe_clr = flag_clear_wr & framing_clear_bit;
  // A frame ending in the clear cycle still sets its flag.
  wire noise_next = (push & noise_acc_reg) | (noise_flag & ~noise_clr);
  wire fe_next = (push & stop_bad_reg) | (framing_error_flag & ~fe_clr);
  wire irq_next = multibuffer & error_irq_on & (noise_next | fe_next);

  rx_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) fifo_inst (
    .clk(clk),
    .nrst(nrst),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(shift_reg),
    .out_valid(fifo_valid),
    .out_ready(load),
    .out_data(fifo_data)
  );

  always_ff @(posedge clk) begin
    line_meta_reg <= link.line;
    line_sync_reg <= line_meta_reg;
    line_prev_reg <= line_sync_reg;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg <= RX_IDLE;
      acc_reg <= '0;
      baud_rate_reg <= BAUD_RESET;
      kernel_src <= SRC_BUS;
    end else begin
      state_reg <= state_next;
      acc_reg <= acc_next;
      if (baud_wr) baud_rate_reg <= baud_wdata;
      // Switching sources while running is unsupported, so only track it while off.
      if (!unit_on_bit) kernel_src <= DUAL_DOMAIN ? clk_src_sel : SRC_BUS;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst || state_reg == RX_IDLE) begin
      cnt_reg <= '0;
      bit_idx_reg <= '0;
    end else if (bit_end) begin
      cnt_reg <= '0;
      bit_idx_reg <= (state_reg == RX_DATA) ? bit_idx_reg + 3'h1 : bit_idx_reg;
    end else if (tick) begin
      cnt_reg <= cnt_inc;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      samp_reg <= '0;
      shift_reg <= '0;
      noise_acc_reg <= 1'b0;
      stop_bad_reg <= 1'b0;
    end else if (go && state_reg == RX_IDLE) begin
      noise_acc_reg <= 1'b0;
      stop_bad_reg <= 1'b0;
    end else begin
      if (take) samp_reg <= {samp_reg[0], line_sync_reg};
      if (noise_hit) noise_acc_reg <= 1'b1;
      if (eval && state_reg == RX_DATA) shift_reg <= {bit_val, shift_reg[DATA_W-1:1]};
      if (eval && in_stop) stop_bad_reg <= ~bit_val;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rx_valid <= 1'b0;
      rx_data_reg <= '0;
      rx_buffer_full <= 1'b0;
      noise_flag <= 1'b0;
      framing_error_flag <= 1'b0;
      error_irq <= 1'b0;
    end else begin
      rx_valid <= valid_next;
      if (load) rx_data_reg <= fifo_data;
      rx_buffer_full <= push | fifo_valid | valid_next;
      noise_flag <= noise_next;
      framing_error_flag <= fe_next;
      error_irq <= irq_next;
    end
  end
endmodule // uart_rx_end

// [logic/uart_far_end.sv]
// Purpose: Far-end transmitter that drives the serial line for the receiver.
// Assumes: bit_clocks gives whole kernel clocks per bit, at least sixteen.
// Notes: stop_low drives the stop period low to model a break or a card's NACK.
module uart_far_end (
  input wire logic clk, // Kernel clock, 10 MHz.
  input wire logic nrst, // Synchronous reset, active low.
  serial_link_if.far link, // Serial line driven here.
  input wire logic [uart_pkg::DIV_W-1:0] bit_clocks, // Clocks per bit.
  input wire logic two_stop, // Send two stop bits.
  input wire logic stop_low, // Hold the line low during stop.
  input wire logic [uart_pkg::DATA_W-1:0] tx_data, // Character to send.
  input wire logic tx_valid, // Send request.
  output logic tx_ready, // Idle and able to accept.
  output logic line_out // Copy of the driven line level.
);
  import uart_pkg::*;

  tx_state_type state_reg;
  logic [DIV_W-1:0] clk_cnt_reg;
  logic [2:0] bit_idx_reg;
  logic stop_idx_reg;
  logic [DATA_W-1:0] data_reg;
  logic line_reg;

  // -------------------------------------------------------------------
  // Bit timing
  // -------------------------------------------------------------------
  wire accept = tx_valid & (state_reg == TX_IDLE);
  wire bit_done = clk_cnt_reg == DIV_W'(bit_clocks - DIV_W'(1));
  wire last_stop = ~two_stop | stop_idx_reg;

  assign link.line = line_reg;
  assign line_out = line_reg;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg <= TX_IDLE;
      clk_cnt_reg <= '0;
      bit_idx_reg <= '0;
      stop_idx_reg <= 1'b0;
      data_reg <= '0;
      line_reg <= 1'b1;
      tx_ready <= 1'b0;
    end else begin
      clk_cnt_reg <= (state_reg == TX_IDLE || bit_done) ? '0 : clk_cnt_reg + DIV_W'(1);
      unique case (state_reg)
        TX_IDLE: begin
          tx_ready <= ~accept;
          if (accept) begin
            data_reg <= tx_data;
            line_reg <= 1'b0;
            state_reg <= TX_START;
          end
        end
        TX_START: begin
          if (bit_done) begin
            line_reg <= data_reg[0];
            bit_idx_reg <= '0;
            state_reg <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (bit_done) begin
            if (bit_idx_reg == LAST_BIT) begin
              line_reg <= ~stop_low;
              stop_idx_reg <= 1'b0;
              state_reg <= TX_STOP;
            end else begin
              data_reg <= {1'b0, data_reg[DATA_W-1:1]};
              line_reg <= data_reg[1];
              bit_idx_reg <= bit_idx_reg + 3'h1;
            end
          end
        end
        TX_STOP: begin
          if (bit_done) begin
            if (last_stop) begin
              line_reg <= 1'b1;
              tx_ready <= 1'b1;
              state_reg <= TX_IDLE;
            end else begin
              stop_idx_reg <= 1'b1;
              // A NACK or break holds the whole stop period low, second stop included.
              line_reg <= ~stop_low;
            end
          end
        end
      endcase
    end
  end
endmodule // uart_far_end

// [verification/uart_rx_props.sv]
// Purpose: Concurrent checks on the link line and the receiver's flags and baud register.
// Assumes: One kernel clock; signals are those of the link and the receiver ports.
// Notes: Set wins over clear, so the clear checks allow a store in the same cycle.
module uart_rx_props (
  input wire logic clk, // Kernel clock.
  input wire logic nrst, // Synchronous reset, active low.
  input wire logic line, // Serial line.
  input wire logic unit_on_bit, // Unit enable.
  input wire logic [1:0] kernel_src, // Active clock source.
  input wire logic single_sample_select, // One sample per bit.
  input wire logic multibuffer, // DMA operation.
  input wire logic error_irq_on, // Error interrupt enable.
  input wire logic baud_wr, // Baud write strobe.
  input wire logic [uart_pkg::DIV_W-1:0] baud_wdata, // Baud write data.
  input wire logic [uart_pkg::DIV_W-1:0] baud_rate_reg, // Baud readback.
  input wire logic flag_clear_wr, // Flag clear strobe.
  input wire logic noise_clear_bit, // Noise clear.
  input wire logic framing_clear_bit, // Framing clear.
  input wire logic rx_ready, // Consumer ready.
  input wire logic [uart_pkg::DATA_W-1:0] rx_data_reg, // Character.
  input wire logic rx_valid, // Character available.
  input wire logic rx_buffer_full, // Data held.
  input wire logic noise_flag, // Noise flag.
  input wire logic framing_error_flag, // Framing error flag.
  input wire logic error_irq // Error interrupt.
);
  timeunit 1ns;
  timeprecision 1ns;
  import uart_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  reset_values_a: assert property ($rose(nrst) |-> line && baud_rate_reg == BAUD_RESET
    && !noise_flag && !framing_error_flag && !rx_buffer_full) else $error("bad state after reset");
  baud_take_a: assert property (baud_wr |=> baud_rate_reg == $past(baud_wdata))
    else $error("baud write not taken");
  baud_hold_a: assert property (!baud_wr |=> $stable(baud_rate_reg))
    else $error("baud register changed without write");
  noise_with_full_a: assert property ($rose(noise_flag) |-> rx_buffer_full)
    else $error("noise flag rose without stored data");
  framing_with_full_a: assert property ($rose(framing_error_flag) |-> rx_buffer_full)
    else $error("framing flag rose without stored data");
  noise_clear_a: assert property (flag_clear_wr && noise_clear_bit |=>
    !noise_flag || rx_buffer_full) else $error("noise flag not cleared");
  framing_clear_a: assert property (flag_clear_wr && framing_clear_bit |=>
    !framing_error_flag || rx_buffer_full) else $error("framing flag not cleared");
  single_quiet_a: assert property (single_sample_select && $past(single_sample_select)
    |-> !$rose(noise_flag)) else $error("noise in single sample mode");
  irq_follows_a: assert property (error_irq ==
    ($past(multibuffer && error_irq_on) && (noise_flag || framing_error_flag)))
    else $error("error interrupt wrong");
  valid_hold_a: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data_reg))
    else $error("character dropped before taken");
  source_lock_a: assert property (unit_on_bit && $past(unit_on_bit) && $past(nrst)
    |-> $stable(kernel_src)) else $error("clock source changed while on");
endmodule // uart_rx_props

// [verification/uart_rx_sampling_baud_gen_bench.sv]
// Purpose: Self-checking bench joining the far-end transmitter to the receiver.
// Assumes: Inputs change at the falling edge; the baud divisor stays at 16 or more.
// Notes: Noise is provoked by a far end slower than the receiver, so bit edges drift into the
// three-sample window; the data of those frames is not checked.
module uart_rx_sampling_baud_gen_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import uart_pkg::*;
  logic clk, nrst, unit_on_bit, rx_side_on, oversample_half_select, single_sample_select;
  logic special_mode, multibuffer, error_irq_on, baud_wr, flag_clear_wr, rx_ready;
  logic noise_clear_bit, framing_clear_bit, two_stop, stop_low, tx_valid, tx_ready;
  logic rx_valid, rx_buffer_full, noise_flag, framing_error_flag, error_irq, line_copy;
  logic [1:0] clk_src_sel, stop_sel, kernel_src;
  logic [DIV_W-1:0] baud_wdata, baud_rate_reg, bit_clocks;
  logic [DATA_W-1:0] tx_data, rx_data_reg;
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;
  serial_link_if link ();
  uart_rx_end u_uart_rx_end (.clk, .nrst, .link(link.device), .unit_on_bit, .rx_side_on,
    .clk_src_sel, .oversample_half_select, .single_sample_select, .special_mode, .stop_sel,
    .multibuffer, .error_irq_on, .baud_wr, .baud_wdata, .flag_clear_wr, .noise_clear_bit,
    .framing_clear_bit, .rx_ready, .rx_data_reg, .rx_valid, .rx_buffer_full, .noise_flag,
    .framing_error_flag, .error_irq, .baud_rate_reg, .kernel_src);
  uart_far_end u_uart_far_end (.clk, .nrst, .link(link.far), .bit_clocks, .two_stop, .stop_low,
    .tx_data, .tx_valid, .tx_ready, .line_out(line_copy));
  uart_rx_props u_uart_rx_props (.clk, .nrst, .line(link.line), .unit_on_bit, .kernel_src,
    .single_sample_select, .multibuffer, .error_irq_on, .baud_wr, .baud_wdata, .baud_rate_reg,
    .flag_clear_wr, .noise_clear_bit, .framing_clear_bit, .rx_ready, .rx_data_reg, .rx_valid,
    .rx_buffer_full, .noise_flag, .framing_error_flag, .error_irq);

  // ------------------------------------------------------------------
  // Clock, timeout and tasks
  // ------------------------------------------------------------------
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  // About 7200 cycles are expected; the ceiling leaves ample margin.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic write_baud(input logic [15:0] v);
    baud_wdata = v;
    baud_wr = 1'h1;
    tick(1);
    baud_wr = 1'h0;
    tick(1);
    check(baud_rate_reg, v, "baud");
  endtask

  task automatic clear_flags();
    {flag_clear_wr, noise_clear_bit, framing_clear_bit} = 3'h7;
    tick(1);
    flag_clear_wr = 1'h0;
    tick(1);
    check(noise_flag, 16'h0, "noise clear");
    check(framing_error_flag, 16'h0, "framing clear");
  endtask

  // Waits until the whole frame, both stop periods included, has left the far end.
  task automatic frame(input logic [7:0] d, input logic [15:0] bc, input logic low);
    tx_data = d;
    bit_clocks = bc;
    stop_low = low;
    tx_valid = 1'h1;
    for (int n = 0; n < 100 && tx_ready !== 1'h1; n++) tick(1);
    tick(1);
    tx_valid = 1'h0;
    tick(1);
    for (int n = 0; n < 1000 && tx_ready !== 1'h1; n++) tick(1);
    tick(4);
  endtask

  task automatic take(input logic [7:0] exp);
    for (int n = 0; n < 50 && rx_valid !== 1'h1; n++) tick(1);
    check(rx_data_reg, exp, "data");
    rx_ready = 1'h1;
    tick(1);
    rx_ready = 1'h0;
    tick(1);
  endtask

  // ------------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------------
  initial begin
    {nrst, unit_on_bit, rx_side_on, oversample_half_select, single_sample_select} = 5'h0;
    {special_mode, multibuffer, error_irq_on, baud_wr, flag_clear_wr, rx_ready} = 6'h0;
    {noise_clear_bit, framing_clear_bit, stop_low, tx_valid} = 4'h0;
    two_stop = 1'h1;
    clk_src_sel = SRC_LOW_EXT;
    stop_sel = STOP_ONE;
    baud_wdata = 16'h0;
    bit_clocks = 16'h20;
    tx_data = 8'h0;
    tick(20);
    nrst = 1'h1;
    tick(2);
    check(baud_rate_reg, BAUD_RESET, "baud reset");
    check(link.line, 16'h1, "idle line");
    check(line_copy, 16'h1, "idle copy");
    check(kernel_src, SRC_LOW_EXT, "source");
    {unit_on_bit, rx_side_on, error_irq_on} = 3'h7;
    clk_src_sel = SRC_CORE;
    tick(3);
    check(kernel_src, SRC_LOW_EXT, "source locked");
    // At 8x the register 0x21 packs a divisor of 0x22, so one bit lasts 17 clocks.
    write_baud(16'h0021);
    for (int i = 0; i < 3; i++) begin
      oversample_half_select = (i > 0);
      special_mode = (i == 2);
      frame(8'h3c + i[7:0], (i == 1) ? 16'h11 : 16'h21, 1'h0);
      take(8'h3c + i[7:0]);
    end
    write_baud(16'h0020);
    {oversample_half_select, special_mode} = 2'h0;
    for (int i = 0; i < 8; i++) begin
      stop_sel = i[1:0];
      multibuffer = i[0];
      frame(8'h81 ^ i[7:0], 16'h20, i[2]);
      take(8'h81 ^ i[7:0]);
      check(noise_flag, 16'h0, "clean");
      check(framing_error_flag, i[2] && stop_sel != STOP_HALF, "framing");
      check(error_irq, i[2] && i[0] && stop_sel != STOP_HALF, "irq");
      clear_flags();
    end
    write_baud(16'h0010);
    for (int i = 0; i < 2; i++) begin
      single_sample_select = i[0];
      frame(8'h55, 16'h12, 1'h0);
      check(rx_buffer_full, 16'h1, "stored");
      check(noise_flag, !i[0], "noise");
      rx_ready = 1'h1;
      tick(3);
      rx_ready = 1'h0;
      clear_flags();
    end
    single_sample_select = 1'h0;
    for (int i = 0; i < 16; i++) frame(i[7:0], 16'h10, 1'h0);
    check(rx_buffer_full, 16'h1, "full");
    for (int i = 0; i < 16; i++) take(i[7:0]);
    tick(4);
    check(rx_buffer_full, 16'h0, "empty");
    give_verdict();
  end
endmodule // uart_rx_sampling_baud_gen_bench
